// ---- src/panel_defines.svh ----
// constants for the front panel control logic
`ifndef PANEL_DEFINES_SVH
`define PANEL_DEFINES_SVH
`define PANEL_ITEM_COUNT 6
`define PANEL_ITEM_W 3
`define PANEL_ITEM_FIRST 3'h0
`define PANEL_ITEM_LAST 3'h5
`define PANEL_DIGITS 8
`define PANEL_CHAR_W 8
`define PANEL_OFFS_CTRL 32'h00000000
`define PANEL_OFFS_STAT 32'h00000004
`define PANEL_OFFS_EVT 32'h00000008
`define PANEL_OFFS_MASK 32'h0000000c
`define PANEL_RESP_OKAY 2'h0
`define PANEL_RESP_SLVERR 2'h2
`define PANEL_EVT_W 4
`endif

// ---- src/panel_pkg.sv ----
// types for the front panel control logic
package panel_pkg;
   typedef enum logic [2:0]
   {
      JIT_NONE = 3'b001,
      JIT_GEN = 3'b010,
      JIT_OUT = 3'b100
   } jitter_path_t;
endpackage

// ---- src/press_detect.sv ----
// one-cycle press pulse from a synchronous button level
module press_detect #(parameter int WIDTH = 1)
(
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [WIDTH-1:0] level, // button levels, high while held
   output logic [WIDTH-1:0] press // one-cycle pulse on rising level
);
   logic [WIDTH-1:0] prev;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev <= '0;
         press <= '0;
      end
      else
      begin
         prev <= level;
         press <= level & ~prev;
      end
   end
endmodule

// ---- src/front_panel_control.sv ----
// front panel lamps, display item choice and control state
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`include "panel_defines.svh"
module front_panel_control
(
   input wire logic aclk, // system clock, 125 MHz
   input wire logic aresetn, // synchronous reset, active low
   input wire logic btn_local, // panel control button level
   input wire logic btn_output_enable, // output enable button level
   input wire logic btn_reference, // reference source button level
   input wire logic btn_jitter, // jitter select button level
   input wire logic btn_up, // scroll up button level
   input wire logic btn_down, // scroll down button level
   input wire logic [`PANEL_ITEM_COUNT-1:0] btn_adjust, // adjust buttons, one per item
   input wire logic remote_take, // remote bus takes control, pulse
   input wire logic any_uncalibrated, // some output is uncalibrated
   input wire logic [`PANEL_ITEM_COUNT*`PANEL_DIGITS*`PANEL_CHAR_W-1:0] item_text, // text per item
   output logic uncalibrated_output_lamp, // uncalibrated lamp
   output logic panel_control_indicator, // local control lamp
   output logic output_enable_lamp, // output enable lamp
   output logic outputs_enabled, // clock outputs driven
   output logic outside_reference_lamp, // external reference lamp
   output logic reference_external, // reference taken from outside input
   output logic [2:0] jitter_lamps, // none, generated, outside lamps
   output logic modulate_generated, // modulate from internal generator
   output logic modulate_outside, // modulate from rear input
   output logic [`PANEL_ITEM_COUNT-1:0] item_lamps, // selected item lamp
   output logic [`PANEL_ITEM_W-1:0] item_index, // selected item number
   output logic [`PANEL_DIGITS*`PANEL_CHAR_W-1:0] display_text, // display characters
   output logic irq, // interrupt, high while unmasked event set
   input wire logic [31:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [31:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready // read data ready
);
   localparam int NB = 5 + `PANEL_ITEM_COUNT;
   localparam int DW = `PANEL_DIGITS * `PANEL_CHAR_W;

   logic [NB-1:0] press;
   logic p_local;
   logic p_enable;
   logic p_ref;
   logic p_jit;
   logic p_up;
   logic p_down;
   logic [`PANEL_ITEM_COUNT-1:0] p_adj;
   logic local_mode;
   logic [`PANEL_ITEM_W-1:0] next_item;
   panel_pkg::jitter_path_t jit;
   logic [`PANEL_EVT_W-1:0] evt;
   logic [`PANEL_EVT_W-1:0] mask;
   logic [`PANEL_EVT_W-1:0] evt_set;
   logic [`PANEL_EVT_W-1:0] evt_clr;
   logic [2:0] sw_cmd;
   logic aw_held;
   logic w_held;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [31:0] rd_word;
   logic rd_ok;

   press_detect #(.WIDTH(NB)) u_press
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .level({btn_adjust, btn_down, btn_up, btn_jitter, btn_reference, btn_output_enable}),
      .press(press)
   );
   assign p_enable = press[0];
   assign p_ref = press[1];
   assign p_jit = press[2];
   assign p_up = press[3];
   assign p_down = press[4];
   assign p_adj = press[NB-1:5];
   assign p_local = btn_local;

   // panel presses act only in local control; the local button always acts
   logic local_edge;
   logic local_prev;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         local_prev <= 1'b0;
      else
         local_prev <= p_local;
   end
   assign local_edge = p_local & ~local_prev;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         local_mode <= 1'b1;
      else if (local_edge)
         local_mode <= 1'b1;
      else if (remote_take)
         local_mode <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         panel_control_indicator <= 1'b1;
      else
         panel_control_indicator <= local_edge | (local_mode & ~remote_take);
   end

   // software control word: bit0 toggles enable, bit1 toggles external ref, bit2 jitter step
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         outputs_enabled <= 1'b0;
      else if ((p_enable & local_mode) | sw_cmd[0])
         outputs_enabled <= ~outputs_enabled;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         output_enable_lamp <= 1'b0;
      else
         output_enable_lamp <= outputs_enabled;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         reference_external <= 1'b0;
      else if ((p_ref & local_mode) | sw_cmd[1])
         reference_external <= ~reference_external;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         outside_reference_lamp <= 1'b0;
      else
         outside_reference_lamp <= reference_external;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         jit <= panel_pkg::JIT_NONE;
      else if ((p_jit & local_mode) | sw_cmd[2])
      begin
         unique case (jit)
            panel_pkg::JIT_NONE: jit <= panel_pkg::JIT_GEN;
            panel_pkg::JIT_GEN: jit <= panel_pkg::JIT_OUT;
            panel_pkg::JIT_OUT: jit <= panel_pkg::JIT_NONE;
            default: jit <= panel_pkg::JIT_NONE;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         jitter_lamps <= 3'h1;
         modulate_generated <= 1'b0;
         modulate_outside <= 1'b0;
      end
      else
      begin
         jitter_lamps <= jit;
         modulate_generated <= (jit == panel_pkg::JIT_GEN);
         modulate_outside <= (jit == panel_pkg::JIT_OUT);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         uncalibrated_output_lamp <= 1'b0;
      else
         uncalibrated_output_lamp <= any_uncalibrated;
   end

   // display item choice; adjust buttons win over scrolling
   always_comb
   begin
      next_item = item_index;
      if (local_mode)
      begin
         if (|p_adj)
         begin
            for (int i = `PANEL_ITEM_COUNT - 1; i >= 0; i--)
               if (p_adj[i])
                  next_item = i[`PANEL_ITEM_W-1:0];
         end
         else if (p_down & ~p_up)
         begin
            if (item_index == `PANEL_ITEM_LAST)
               next_item = `PANEL_ITEM_FIRST;
            else
               next_item = item_index + 3'h1;
         end
         else if (p_up & ~p_down)
         begin
            if (item_index == `PANEL_ITEM_FIRST)
               next_item = `PANEL_ITEM_LAST;
            else
               next_item = item_index - 3'h1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         item_index <= `PANEL_ITEM_FIRST;
      else
         item_index <= next_item;
   end

   genvar g;
   generate
      for (g = 0; g < `PANEL_ITEM_COUNT; g++)
      begin : g_lamp
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               item_lamps[g] <= (g == 0);
            else
               item_lamps[g] <= (next_item == g);
         end
      end
   endgenerate

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         display_text <= '0;
      else
         display_text <= item_text[next_item*DW +: DW];
   end

   // events: 0 local regained, 1 remote taken, 2 uncalibrated rise, 3 panel press
   assign evt_set = {|press, any_uncalibrated & ~uncalibrated_output_lamp,
                     remote_take & local_mode, local_edge & ~local_mode};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         evt <= '0;
      else
         evt <= (evt & ~evt_clr) | evt_set; // set wins over clear
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(((evt & ~evt_clr) | evt_set) & mask);
   end

   // axi4-lite write path
   assign do_write = aw_held & w_held & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PANEL_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[31:2] <= `PANEL_OFFS_MASK >> 2) ?
                           `PANEL_RESP_OKAY : `PANEL_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_comb
   begin
      sw_cmd = 3'h0;
      evt_clr = '0;
      if (do_write & w_strb[0])
      begin
         if (aw_addr[31:2] == `PANEL_OFFS_CTRL >> 2)
            sw_cmd = w_data[2:0];
         if (aw_addr[31:2] == `PANEL_OFFS_EVT >> 2)
            evt_clr = w_data[`PANEL_EVT_W-1:0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask <= '0;
      else if (do_write & w_strb[0] & (aw_addr[31:2] == `PANEL_OFFS_MASK >> 2))
         mask <= w_data[`PANEL_EVT_W-1:0];
   end

   // axi4-lite read path
   always_comb
   begin
      rd_ok = 1'b1;
      rd_word = '0;
      unique case (s_axi_araddr[31:2])
         `PANEL_OFFS_CTRL >> 2: rd_word = '0;
         `PANEL_OFFS_STAT >> 2: rd_word = {22'h0, item_index, jit, reference_external,
                                           outputs_enabled, local_mode, any_uncalibrated};
         `PANEL_OFFS_EVT >> 2: rd_word = {28'h0, evt};
         `PANEL_OFFS_MASK >> 2: rd_word = {28'h0, mask};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `PANEL_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `PANEL_RESP_OKAY : `PANEL_RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- dv/panel_monitor.sv ----
// checker for the front panel lamps, control state and display choice
module panel_monitor
(
   input wire logic aclk, // system clock
   input wire logic aresetn, // reset, active low
   input wire logic btn_local, // local button
   input wire logic btn_up, // scroll up
   input wire logic btn_down, // scroll down
   input wire logic [5:0] btn_adjust, // adjust buttons
   input wire logic remote_take, // remote takes control
   input wire logic any_uncalibrated, // uncalibrated level
   input wire logic [383:0] item_text, // item texts
   input wire logic uncalibrated_output_lamp, // lamp
   input wire logic panel_control_indicator, // lamp
   input wire logic output_enable_lamp, // lamp
   input wire logic outputs_enabled, // state
   input wire logic outside_reference_lamp, // lamp
   input wire logic reference_external, // state
   input wire logic [2:0] jitter_lamps, // lamps
   input wire logic [5:0] item_lamps, // lamps
   input wire logic [2:0] item_index, // item
   input wire logic [63:0] display_text // display
);
   // display text is loaded from the text seen one edge earlier
   logic [383:0] text_q;
   always_ff @(posedge aclk)
   begin
      text_q <= item_text;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a scroll press that the device must obey
   sequence s_step(b);
      $rose(b) && !(btn_up && btn_down) && btn_adjust == 6'h00 && panel_control_indicator;
   endsequence
   property p_uncal;
      1 |=> uncalibrated_output_lamp == $past(any_uncalibrated);
   endproperty
   a_uncal: assert property (p_uncal) else $error("uncalibrated lamp wrong");
   property p_text;
      $past(aresetn) |-> display_text == text_q[item_index * 64 +: 64];
   endproperty
   a_text: assert property (p_text) else $error("display text wrong");
   property p_adjust;
      btn_adjust != 6'h00 && $past(btn_adjust) == 6'h00 && panel_control_indicator
      |-> ##2 item_lamps == ($past(btn_adjust, 2) & (~$past(btn_adjust, 2) + 6'h01));
   endproperty
   a_adjust: assert property (p_adjust) else $error("adjust item wrong");
   property p_remote;
      remote_take && !btn_local |=> !panel_control_indicator;
   endproperty
   a_remote: assert property (p_remote) else $error("remote not shown");
   property p_fall;
      $fell(panel_control_indicator) |-> $past(remote_take);
   endproperty
   a_fall: assert property (p_fall) else $error("local lost without cause");
   property p_local;
      $rose(btn_local) && !remote_take |=> panel_control_indicator;
   endproperty
   a_local: assert property (p_local) else $error("local not regained");
   property p_lamps;
      1 |=> {output_enable_lamp, outside_reference_lamp}
         == $past({outputs_enabled, reference_external});
   endproperty
   a_lamps: assert property (p_lamps) else $error("enable or reference lamp wrong");
   property p_onehot;
      $onehot(jitter_lamps) && item_lamps == (6'h01 << item_index) && item_index <= 3'h5;
   endproperty
   a_onehot: assert property (p_onehot) else $error("lamp set wrong");
   property p_down;
      s_step(btn_down) |-> ##2 item_index
         == (($past(item_index, 2) == 3'h5) ? 3'h0 : $past(item_index, 2) + 3'h1);
   endproperty
   a_down: assert property (p_down) else $error("down step wrong");
   property p_up;
      s_step(btn_up) |-> ##2 item_index
         == (($past(item_index, 2) == 3'h0) ? 3'h5 : $past(item_index, 2) - 3'h1);
   endproperty
   a_up: assert property (p_up) else $error("up step wrong");
endmodule
bind front_panel_control panel_monitor i_mon (.aclk, .aresetn, .btn_local, .btn_up, .btn_down,
   .btn_adjust, .remote_take, .any_uncalibrated, .item_text, .uncalibrated_output_lamp,
   .panel_control_indicator, .output_enable_lamp, .outputs_enabled, .outside_reference_lamp,
   .reference_external, .jitter_lamps, .item_lamps, .item_index, .display_text);

// ---- dv/panel_operator.sv ----
// operator at the panel buttons and the remote bus controller
module panel_operator
(
   input wire logic aclk, // system clock
   output logic [11:0] keys, // adjust 11:6, down, up, jitter, ref, enable, local
   output logic remote_take // remote takes control
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      keys = 12'h000;
      remote_take = 1'b0;
   end
   // hold for two edges, then a release gap until lamps settle
   task press(input int k);
      @(posedge aclk);
      keys[k] <= 1'b1;
      repeat (2) @(posedge aclk);
      keys[k] <= 1'b0;
      repeat (3) @(posedge aclk);
      #1;
   endtask
   task take();
      @(posedge aclk);
      remote_take <= 1'b1;
      @(posedge aclk);
      remote_take <= 1'b0;
      repeat (2) @(posedge aclk);
      #1;
   endtask
endmodule

// ---- dv/tb_front_panel_control.sv ----
// self-checking bench for the front panel control logic
module tb_front_panel_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, any_uncalibrated, remote_take, irq;
   logic [383:0] item_text;
   logic [11:0] keys;
   logic uncalibrated_output_lamp, panel_control_indicator, output_enable_lamp;
   logic outputs_enabled, outside_reference_lamp, reference_external;
   logic modulate_generated, modulate_outside;
   logic [2:0] jitter_lamps, item_index;
   logic [5:0] item_lamps;
   logic [63:0] display_text;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int err_count = 0;
   int n_checks = 0;
   panel_operator i_op (.aclk, .keys, .remote_take);
   front_panel_control i_dut (.aclk, .aresetn, .btn_local(keys[0]), .btn_output_enable(keys[1]),
      .btn_reference(keys[2]), .btn_jitter(keys[3]), .btn_up(keys[4]), .btn_down(keys[5]),
      .btn_adjust(keys[11:6]), .remote_take, .any_uncalibrated, .item_text,
      .uncalibrated_output_lamp, .panel_control_indicator, .output_enable_lamp, .outputs_enabled,
      .outside_reference_lamp, .reference_external, .jitter_lamps, .modulate_generated,
      .modulate_outside, .item_lamps, .item_index, .display_text, .irq, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task too_long(input int k);
      if (k == 50)
      begin
         err_count++;
         complete_run();
      end
   endtask
   task axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
            break;
      end
      too_long(k);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask
   task axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
            break;
      end
      too_long(k);
      s_axi_rready <= 1'b0;
      chk("rresp", er, s_axi_rresp);
      chk("rdata", ed, s_axi_rdata);
   endtask
   initial
   begin
      {aresetn, any_uncalibrated, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hf;
      for (int i = 0; i < 6; i++)
         item_text[i * 64 +: 64] = {8{8'h41 + 8'(i)}};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      #1;
      chk("local", 1'b1, panel_control_indicator);
      chk("enable", 2'h0, {output_enable_lamp, outputs_enabled});
      chk("ref", 1'b0, outside_reference_lamp);
      chk("jitter", 3'h1, jitter_lamps);
      chk("items", 6'h01, item_lamps);
      chk("text", item_text[63:0], display_text);
      chk("uncal", 1'b0, uncalibrated_output_lamp);
      for (int v = 1; v >= 0; v--)
      begin
         @(posedge aclk);
         any_uncalibrated <= v[0];
         repeat (2) @(posedge aclk);
         #1;
         chk("uncal", v, uncalibrated_output_lamp);
      end
      $display("reset and uncalibrated tests done");
      for (int i = 1; i <= 7; i++)
      begin
         i_op.press(5);
         chk("item", i % 6, item_index);
         chk("items", 6'h01 << (i % 6), item_lamps);
         chk("text", item_text[(i % 6) * 64 +: 64], display_text);
      end
      i_op.press(4);
      chk("item", 3'h0, item_index);
      i_op.press(4);
      chk("item", 3'h5, item_index);
      for (int i = 0; i < 6; i++)
      begin
         i_op.press(6 + i);
         chk("item", i, item_index);
      end
      @(posedge aclk);
      item_text[383:320] <= 64'h5a5a5a5a5a5a5a5a;
      repeat (2) @(posedge aclk);
      #1;
      chk("text", 64'h5a5a5a5a5a5a5a5a, display_text);
      $display("scroll and adjust tests done");
      i_op.press(1);
      chk("enable", 2'h3, {output_enable_lamp, outputs_enabled});
      i_op.press(2);
      chk("ref", 2'h3, {outside_reference_lamp, reference_external});
      for (int i = 1; i <= 3; i++)
      begin
         i_op.press(3);
         chk("jitter", 3'h1 << (i % 3), jitter_lamps);
         chk("modulate", (3'h1 << (i % 3)) >> 1, {modulate_outside, modulate_generated});
      end
      i_op.take();
      chk("local", 1'b0, panel_control_indicator);
      i_op.press(5);
      chk("item", 3'h5, item_index);
      i_op.press(0);
      chk("local", 1'b1, panel_control_indicator);
      $display("control tests done");
      axr(32'h0000000c, 32'h00000000, 2'h0);
      axw(32'h0000000c, 32'h00000003, 2'h0);
      axr(32'h0000000c, 32'h00000003, 2'h0);
      axr(32'h00000004, 32'h0000029e, 2'h0);
      axr(32'h00000008, 32'h0000000f, 2'h0);
      chk("irq", 1'b1, irq);
      axw(32'h00000008, 32'h00000003, 2'h0);
      repeat (2) @(posedge aclk);
      #1;
      chk("irq", 1'b0, irq);
      axr(32'h00000008, 32'h0000000c, 2'h0);
      axr(32'h00000010, 32'h00000000, 2'h2);
      axw(32'h00000010, 32'h00000003, 2'h2);
      axw(32'h00000000, 32'h00000001, 2'h0);
      s_axi_wstrb <= 4'he;
      axw(32'h00000000, 32'h00000001, 2'h0);
      s_axi_wstrb <= 4'hf;
      axr(32'h00000000, 32'h00000000, 2'h0);
      repeat (3) @(posedge aclk);
      #1;
      chk("enable", 2'h0, {output_enable_lamp, outputs_enabled});
      $display("register tests done");
      complete_run();
   end
endmodule
